// File: core/ssb_pkg.sv
// Purpose: shared constants for the servo stop and brake sequencer
// Assumes: 125 MHz hclk, AHB-Lite register access, 32-bit word registers
// Notes:   register offsets are byte addresses of aligned words
package ssb_pkg;
    // clock and timing
    localparam int CLK_PERIOD_NS = 8;             // hclk period
    localparam int UNIT_TIME_NS = 2000000;        // one delay unit is 2 ms
    localparam int UNIT_CYCLES = UNIT_TIME_NS / CLK_PERIOD_NS;
    localparam int SLOW_SPEED_RPM = 30;           // brake may drop at this speed

    // register offsets
    localparam logic [7:0] ADDR_CTRL = 8'h00;     // stop selections, alarm policy
    localparam logic [7:0] ADDR_BRAKE = 8'h04;    // brake delays
    localparam logic [7:0] ADDR_HOLD = 8'h08;     // momentary hold time
    localparam logic [7:0] ADDR_STATUS = 8'h0c;   // live state, read only
    localparam logic [7:0] ADDR_IRQ_STAT = 8'h10; // sticky events, write one to clear
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h14; // interrupt enables

    // ctrl field positions
    localparam int CTRL_PLOSS_LSB = 0;            // power_loss_stop_select, 4 bits
    localparam int CTRL_SOFF_LSB = 4;             // servo_off_stop_select, 4 bits
    localparam int CTRL_ALARM_LSB = 8;            // alarm_stop_select, 2 bits
    localparam int CTRL_UVSEL_BIT = 10;           // undervoltage_alarm_select
    localparam int CTRL_REGEN_LSB = 12;           // regen_resistor_select, 2 bits
    // brake field positions
    localparam int BRAKE_STOP_LSB = 0;            // stopped_brake_delay, 7 bits
    localparam int BRAKE_RUN_LSB = 16;            // running_brake_delay, 7 bits

    // values after reset
    localparam logic [3:0] RST_PLOSS_SEL = 4'h0;
    localparam logic [3:0] RST_SOFF_SEL = 4'h0;
    localparam logic [1:0] RST_ALARM_SEL = 2'h0;
    localparam logic RST_UV_SEL = 1'b1;
    localparam logic [1:0] RST_REGEN_SEL = 2'h0;
    localparam logic [6:0] RST_STOP_DELAY = 7'h0a;   // 10 units
    localparam logic [6:0] RST_RUN_DELAY = 7'h32;    // 50 units
    localparam logic [9:0] RST_HOLD_TIME = 10'h023;  // 35 units

    // limits
    localparam logic [6:0] MAX_BRAKE_DELAY = 7'h64;  // 100 units
    localparam logic [9:0] MIN_HOLD_TIME = 10'h023;  // 35 units
    localparam logic [9:0] MAX_HOLD_TIME = 10'h3e8;  // 1000 units
    localparam logic [3:0] MAX_STOP_SEL = 4'h9;
    localparam logic [6:0] REGEN_INT_LIMIT = 7'h01;  // internal resistor, about 1 %
    localparam logic [6:0] REGEN_EXT_LIMIT = 7'h0a;  // external resistor, 10 %

    // interrupt bits
    localparam int IRQ_SHUTOFF = 0;               // main-power shutoff declared
    localparam int IRQ_ALARM = 1;                 // protective stop started
    localparam int IRQ_SERVO_OFF = 2;             // servo-off stop started
    localparam int IRQ_REGEN = 3;                 // regeneration overload tripped
    localparam int IRQ_WIDTH = 4;

    // sequencer states
    typedef enum logic [2:0] {
        SSB_ST_STOPPED = 3'b000,  // motor unpowered, after-stop action held
        SSB_ST_RUN = 3'b001,      // servo on
        SSB_ST_DECEL = 3'b010,    // stopping, deceleration action applied
        SSB_ST_HOLD = 3'b011      // stopped on servo off, waiting brake delay
    } ssb_state_e;

    // deceleration actions
    typedef enum logic [1:0] {
        SSB_DEC_DB = 2'b00,       // dynamic brake
        SSB_DEC_FREE = 2'b01,     // free run
        SSB_DEC_ESTOP = 2'b10     // emergency stop
    } ssb_dec_e;
endpackage

// File: core/ssb_sequencer.sv
// Purpose: stop-sequence and holding-brake controller of a servo drive
// Assumes: run, supply and trip inputs are asynchronous pins; speed and
//          regeneration rate come from logic on hclk
// Notes:   registers over AHB-Lite, one level interrupt
// Functional notes
// - settings 0-7: odd free run, 2/3/6/7 free after
// - settings 4-7 hold deviation counter, others clear
// - settings 8/9 emergency stop; 8 brake, 9 free
// - protective trip uses alarm selection bits 0 and 1
// - run off applies servo-off selection, same encoding
// - stopped at run off: brake drops, power after delay
// - rotating: brake drops after delay or at 30 rpm
// - selection 0: regen on, alarm past about 1 %
// - selection 1: regen on, alarm past 10 %
// - selection 2: regen on, never alarms
// - selection 3: regen and alarm off, after power cycle
// - shutoff declared after hold time; new value after cycle
// - power-loss selection only when undervoltage selection 0
//
// Added by the designer: register access over AHB-Lite and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module ssb_sequencer
    import ssb_pkg::*;
#(
    parameter int UNIT_CYC = UNIT_CYCLES,   // cycles per 2 ms delay unit
    parameter int SPEED_W = 16              // width of the speed estimate
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [7:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic run_cmd,
    input wire logic main_supply_ok,
    input wire logic protect_trip,
    input wire logic [SPEED_W-1:0] speed_rpm,
    input wire logic [6:0] regen_rate_pct,
    output logic servo_power_on,
    output logic cmd_dyn_brake,
    output logic cmd_free_run,
    output logic cmd_estop,
    output logic cmd_servo_free,
    output logic brake_release_out,
    output logic dev_counter_clear,
    output logic regen_enable,
    output logic regen_alarm,
    output logic undervoltage_alarm,
    output logic supply_shutoff,
    output logic irq
);
    initial begin
        if (UNIT_CYC < 1 || SPEED_W < 6) begin
            $error("ssb_sequencer: bad parameters");
        end
    end

    // decoded stop action: deceleration, free after stop, keep deviation
    typedef struct packed {
        ssb_dec_e dec;
        logic free_after;
        logic keep_dev;
    } ssb_act_s;

    // decode a 0..9 stop selection; out-of-range values act as 0
    function automatic ssb_act_s sel_decode(input logic [3:0] sel);
        ssb_act_s a;
        a = '{dec: SSB_DEC_DB, free_after: 1'b0, keep_dev: 1'b0};
        if (sel > MAX_STOP_SEL) begin
            a = '{dec: SSB_DEC_DB, free_after: 1'b0, keep_dev: 1'b0};
        end else if (sel[3]) begin
            a.dec = SSB_DEC_ESTOP;
            a.free_after = sel[0];
        end else begin
            a.dec = sel[0] ? SSB_DEC_FREE : SSB_DEC_DB;
            a.free_after = sel[1];
            a.keep_dev = sel[2];
        end
        return a;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // input synchronisers
    logic [2:0] sync1_r;  // first stage, read only by the second
    logic [2:0] sync2_r;  // run, supply ok, trip
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sync1_r <= 3'b010;
            sync2_r <= 3'b010;
        end else begin
            sync1_r <= {protect_trip, main_supply_ok, run_cmd};
            sync2_r <= sync1_r;
        end
    end
    logic run_s, supply_s, trip_s;
    assign run_s = sync2_r[0];
    assign supply_s = sync2_r[1];
    assign trip_s = sync2_r[2];

    ////////////////////////////////////////////////////////////////////////
    // bus address phase capture
    logic dp_valid_r;  // a word transfer is in its data phase
    logic dp_write_r;
    logic [7:0] dp_addr_r;
    logic ap_take;
    assign ap_take = hsel && htrans[1] && hready;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dp_valid_r <= 1'b0;
            dp_write_r <= 1'b0;
            dp_addr_r <= 8'h00;
        end else begin
            // only whole-word writes are honoured; other writes pass as no-ops
            dp_valid_r <= ap_take && (hsize == 3'h2);
            dp_write_r <= hwrite;
            dp_addr_r <= haddr;
        end
    end
    assign hreadyout = 1'b1;  // zero wait states
    assign hresp = 1'b0;  // always okay

    logic wr_en;
    assign wr_en = dp_valid_r && dp_write_r;

    ////////////////////////////////////////////////////////////////////////
    // software registers
    logic [3:0] ploss_sel_r, soff_sel_r;
    logic [1:0] alarm_sel_r;
    logic uv_sel_r;
    logic [1:0] regen_sel_r;   // written value, not yet in force
    logic [6:0] stop_dly_r, run_dly_r;
    logic [9:0] hold_time_r;   // written value, not yet in force
    logic [IRQ_WIDTH-1:0] irq_mask_r;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ploss_sel_r <= RST_PLOSS_SEL;
            soff_sel_r <= RST_SOFF_SEL;
            alarm_sel_r <= RST_ALARM_SEL;
            uv_sel_r <= RST_UV_SEL;
            regen_sel_r <= RST_REGEN_SEL;
            stop_dly_r <= RST_STOP_DELAY;
            run_dly_r <= RST_RUN_DELAY;
            hold_time_r <= RST_HOLD_TIME;
            irq_mask_r <= '0;
        end else if (wr_en) begin
            case (dp_addr_r)
                ADDR_CTRL: begin
                    ploss_sel_r <= hwdata[CTRL_PLOSS_LSB +: 4];
                    soff_sel_r <= hwdata[CTRL_SOFF_LSB +: 4];
                    alarm_sel_r <= hwdata[CTRL_ALARM_LSB +: 2];
                    uv_sel_r <= hwdata[CTRL_UVSEL_BIT];
                    regen_sel_r <= hwdata[CTRL_REGEN_LSB +: 2];
                end
                ADDR_BRAKE: begin
                    // delays above 100 units saturate at the top of range
                    stop_dly_r <= (hwdata[BRAKE_STOP_LSB +: 7] > MAX_BRAKE_DELAY) ?
                        MAX_BRAKE_DELAY : hwdata[BRAKE_STOP_LSB +: 7];
                    run_dly_r <= (hwdata[BRAKE_RUN_LSB +: 7] > MAX_BRAKE_DELAY) ?
                        MAX_BRAKE_DELAY : hwdata[BRAKE_RUN_LSB +: 7];
                end
                ADDR_HOLD: begin
                    if (hwdata[9:0] < MIN_HOLD_TIME) begin
                        hold_time_r <= MIN_HOLD_TIME;
                    end else if (hwdata[9:0] > MAX_HOLD_TIME) begin
                        hold_time_r <= MAX_HOLD_TIME;
                    end else begin
                        hold_time_r <= hwdata[9:0];
                    end
                end
                ADDR_IRQ_MASK: irq_mask_r <= hwdata[IRQ_WIDTH-1:0];
                default: ;  // status and unmapped: writes ignored
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // main supply loss detection and power-cycle settings
    logic [31:0] loss_pre_r;   // cycles inside the current unit
    logic [9:0] loss_cnt_r;    // whole units of continuous loss
    logic shutoff_r;
    logic [1:0] regen_act_r;   // regeneration selection in force
    logic [9:0] hold_act_r;    // hold time in force
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            loss_pre_r <= '0;
            loss_cnt_r <= '0;
            shutoff_r <= 1'b0;
            regen_act_r <= RST_REGEN_SEL;
            hold_act_r <= RST_HOLD_TIME;
        end else if (supply_s) begin
            loss_pre_r <= '0;
            loss_cnt_r <= '0;
            shutoff_r <= 1'b0;
            if (shutoff_r) begin
                // supply back after a shutoff is a power cycle
                regen_act_r <= regen_sel_r;
                hold_act_r <= hold_time_r;
            end
        end else if (!shutoff_r) begin
            if (loss_pre_r == 32'(UNIT_CYC - 1)) begin
                loss_pre_r <= '0;
                loss_cnt_r <= loss_cnt_r + 10'h001;
            end else begin
                loss_pre_r <= loss_pre_r + 32'h1;
            end
            if (loss_cnt_r >= hold_act_r) begin
                shutoff_r <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // regeneration policy
    logic regen_trip_r;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            regen_trip_r <= 1'b0;
        end else if (supply_s && shutoff_r) begin
            regen_trip_r <= 1'b0;  // cleared by the power cycle
        end else begin
            case (regen_act_r)
                2'h0: if (regen_rate_pct > REGEN_INT_LIMIT) regen_trip_r <= 1'b1;
                2'h1: if (regen_rate_pct > REGEN_EXT_LIMIT) regen_trip_r <= 1'b1;
                default: regen_trip_r <= 1'b0;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // stop causes
    logic run_d_r;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            run_d_r <= 1'b0;
        end else begin
            run_d_r <= run_s;
        end
    end
    logic alarm_any, ploss_stop, soff_stop, stopped, slow;
    assign alarm_any = trip_s || regen_trip_r || (shutoff_r && uv_sel_r);
    assign ploss_stop = shutoff_r && !uv_sel_r;
    assign soff_stop = run_d_r && !run_s;
    assign stopped = (speed_rpm == '0);
    assign slow = (speed_rpm <= SPEED_W'(SLOW_SPEED_RPM));

    ////////////////////////////////////////////////////////////////////////
    // sequencer
    ssb_state_e state_r;
    ssb_act_s act_r;          // latched stop action
    logic [31:0] unit_pre_r;  // cycles inside current brake unit
    logic [6:0] unit_cnt_r;   // elapsed brake units
    logic brake_rel_r;
    logic [IRQ_WIDTH-1:0] ev_set;
    ssb_act_s alarm_act;
    always_comb begin
        alarm_act.dec = alarm_sel_r[0] ? SSB_DEC_FREE : SSB_DEC_DB;
        alarm_act.free_after = alarm_sel_r[1];
        alarm_act.keep_dev = 1'b0;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_r <= SSB_ST_STOPPED;
            act_r <= '{dec: SSB_DEC_DB, free_after: 1'b1, keep_dev: 1'b0};
            unit_pre_r <= '0;
            unit_cnt_r <= '0;
            brake_rel_r <= 1'b0;
        end else begin
            // brake delay units count outside run; run holds them at zero, so they restart on leaving it
            if (unit_pre_r == 32'(UNIT_CYC - 1)) begin
                unit_pre_r <= '0;
                if (unit_cnt_r != 7'h7f) unit_cnt_r <= unit_cnt_r + 7'h01;
            end else begin
                unit_pre_r <= unit_pre_r + 32'h1;
            end
            case (state_r)
                SSB_ST_RUN: begin
                    unit_pre_r <= '0;
                    unit_cnt_r <= '0;
                    if (alarm_any || ploss_stop || soff_stop) begin
                        // alarm has priority over power loss over servo off
                        if (alarm_any) act_r <= alarm_act;
                        else if (ploss_stop) act_r <= sel_decode(ploss_sel_r);
                        else act_r <= sel_decode(soff_sel_r);
                        if (stopped && !alarm_any && !ploss_stop) begin
                            brake_rel_r <= 1'b0;
                            state_r <= SSB_ST_HOLD;
                        end else if (stopped) begin
                            brake_rel_r <= 1'b0;
                            state_r <= SSB_ST_STOPPED;
                        end else begin
                            state_r <= SSB_ST_DECEL;
                        end
                    end
                end
                SSB_ST_DECEL: begin
                    if (slow || unit_cnt_r >= run_dly_r) begin
                        brake_rel_r <= 1'b0;
                    end
                    if (stopped) begin
                        brake_rel_r <= 1'b0;
                        state_r <= SSB_ST_STOPPED;
                    end
                end
                SSB_ST_HOLD: begin
                    // a fault while waiting cuts power at once
                    if (unit_cnt_r >= stop_dly_r || alarm_any || ploss_stop) begin
                        state_r <= SSB_ST_STOPPED;
                    end
                end
                SSB_ST_STOPPED: begin
                    if (run_s && !alarm_any && !ploss_stop && !shutoff_r) begin
                        brake_rel_r <= 1'b1;
                        state_r <= SSB_ST_RUN;
                    end
                end
                default: state_r <= SSB_ST_STOPPED;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // power stage commands, at most one active, registered
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            servo_power_on <= 1'b0;
            cmd_dyn_brake <= 1'b0;
            cmd_free_run <= 1'b0;
            cmd_estop <= 1'b0;
            cmd_servo_free <= 1'b1;
            dev_counter_clear <= 1'b1;
        end else begin
            servo_power_on <= (state_r == SSB_ST_RUN) || (state_r == SSB_ST_HOLD);
            cmd_dyn_brake <= 1'b0;
            cmd_free_run <= 1'b0;
            cmd_estop <= 1'b0;
            cmd_servo_free <= 1'b0;
            dev_counter_clear <= !act_r.keep_dev && (state_r != SSB_ST_RUN);
            case (state_r)
                SSB_ST_DECEL: begin
                    cmd_dyn_brake <= (act_r.dec == SSB_DEC_DB);
                    cmd_free_run <= (act_r.dec == SSB_DEC_FREE);
                    cmd_estop <= (act_r.dec == SSB_DEC_ESTOP);
                end
                SSB_ST_STOPPED: begin
                    cmd_dyn_brake <= !act_r.free_after;
                    cmd_servo_free <= act_r.free_after;
                end
                default: ;  // powered states: no stop command
            endcase
        end
    end
    assign brake_release_out = brake_rel_r;
    assign regen_enable = (regen_act_r != 2'h3);
    assign regen_alarm = regen_trip_r;
    assign undervoltage_alarm = shutoff_r && uv_sel_r;
    assign supply_shutoff = shutoff_r;

    ////////////////////////////////////////////////////////////////////////
    // interrupt status, set wins over a write-one clear
    logic [IRQ_WIDTH-1:0] irq_stat_r;
    logic shutoff_d_r, regen_d_r;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            shutoff_d_r <= 1'b0;
            regen_d_r <= 1'b0;
        end else begin
            shutoff_d_r <= shutoff_r;
            regen_d_r <= regen_trip_r;
        end
    end
    always_comb begin
        ev_set = '0;
        ev_set[IRQ_SHUTOFF] = shutoff_r && !shutoff_d_r;
        ev_set[IRQ_REGEN] = regen_trip_r && !regen_d_r;
        ev_set[IRQ_ALARM] = (state_r == SSB_ST_RUN) && alarm_any;
        ev_set[IRQ_SERVO_OFF] = (state_r == SSB_ST_RUN) && soff_stop && !alarm_any
            && !ploss_stop;
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_stat_r <= '0;
        end else if (wr_en && dp_addr_r == ADDR_IRQ_STAT) begin
            irq_stat_r <= (irq_stat_r & ~hwdata[IRQ_WIDTH-1:0]) | ev_set;
        end else begin
            irq_stat_r <= irq_stat_r | ev_set;
        end
    end
    assign irq = |(irq_stat_r & irq_mask_r);

    ////////////////////////////////////////////////////////////////////////
    // read data, loaded at the address phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (ap_take && !hwrite) begin
            hrdata <= 32'h0000_0000;
            case (haddr)
                ADDR_CTRL: begin
                    hrdata[CTRL_PLOSS_LSB +: 4] <= ploss_sel_r;
                    hrdata[CTRL_SOFF_LSB +: 4] <= soff_sel_r;
                    hrdata[CTRL_ALARM_LSB +: 2] <= alarm_sel_r;
                    hrdata[CTRL_UVSEL_BIT] <= uv_sel_r;
                    hrdata[CTRL_REGEN_LSB +: 2] <= regen_sel_r;
                end
                ADDR_BRAKE: begin
                    hrdata[BRAKE_STOP_LSB +: 7] <= stop_dly_r;
                    hrdata[BRAKE_RUN_LSB +: 7] <= run_dly_r;
                end
                ADDR_HOLD: hrdata[9:0] <= hold_time_r;
                ADDR_STATUS: begin
                    hrdata[2:0] <= state_r;
                    hrdata[4] <= brake_rel_r;
                    hrdata[5] <= shutoff_r;
                    hrdata[6] <= regen_trip_r;
                    hrdata[7] <= run_s;
                    hrdata[9:8] <= regen_act_r;
                    hrdata[25:16] <= hold_act_r;
                end
                ADDR_IRQ_STAT: hrdata[IRQ_WIDTH-1:0] <= irq_stat_r;
                ADDR_IRQ_MASK: hrdata[IRQ_WIDTH-1:0] <= irq_mask_r;
                default: ;  // unmapped reads zero
            endcase
        end
    end
endmodule
`default_nettype wire

// File: test/ssb_sequencer_properties.sv
// Purpose: port assertions for the stop and brake sequencer
// Assumes: one hclk domain, hresetn low resets
// Notes:   bound onto ssb_sequencer from tb
`timescale 1ns/1ps
`default_nettype none
module ssb_chk (
    input wire logic hclk, hresetn, run_cmd, main_supply_ok, servo_power_on,
    input wire logic cmd_dyn_brake, cmd_free_run, cmd_estop, cmd_servo_free,
    input wire logic brake_release_out, regen_alarm, supply_shutoff
);
    ////////////////////////////////////////////////////////////////////////
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    logic [3:0] cmds; // the four stop commands side by side
    assign cmds = {cmd_dyn_brake, cmd_free_run, cmd_estop, cmd_servo_free};
    // five cycles outlasts the pin synchroniser, so no power can follow
    sequence s_run_low; !run_cmd [*5]; endsequence
    property p_one_hot; $onehot0(cmds); endproperty
    a_one_hot: assert property (p_one_hot) else $error("stop commands overlap");
    property p_run_low; s_run_low |-> !$rose(servo_power_on); endproperty
    a_run_low: assert property (p_run_low) else $error("power without run");
    property p_pow_up; $rose(servo_power_on) |-> cmds == 4'h0 && brake_release_out; endproperty
    a_pow_up: assert property (p_pow_up) else $error("bad start of run");
    property p_hold; $fell(brake_release_out) && cmds == 4'h0 |=> servo_power_on [*8]; endproperty
    a_hold: assert property (p_hold) else $error("power lost with brake");
    property p_free; cmd_servo_free |-> !servo_power_on; endproperty
    a_free: assert property (p_free) else $error("free while powered");
    property p_shut; $rose(supply_shutoff) |-> !$past(main_supply_ok, 100); endproperty
    a_shut: assert property (p_shut) else $error("shutoff too early");
    property p_shut_stop; $rose(supply_shutoff) |-> ##[0:4] cmds != 4'h0; endproperty
    a_shut_stop: assert property (p_shut_stop) else $error("no stop on shutoff");
    property p_sticky; regen_alarm && !supply_shutoff |=> regen_alarm; endproperty
    a_sticky: assert property (p_sticky) else $error("regen alarm dropped");
endmodule
`default_nettype wire

// File: test/ssb_motor_model.sv
// Purpose: motor and holding brake behind the power stage
// Assumes: speed tracks set_rpm only while driven with brake released
// Notes:   coasting loses 2 r/min a cycle, braking 8
`timescale 1ns/1ps
`default_nettype none
module ssb_motor_model (
    input wire logic hclk, servo_power_on, brake_release_out, cmd_free_run, stopping,
    input wire logic [15:0] set_rpm,
    output logic [15:0] speed_rpm = 16'h0
);
    logic [15:0] step; // slower loss when coasting than when braking
    assign step = cmd_free_run ? 16'h2 : 16'h8;
    ////////////////////////////////////////////////////////////////////////
    // driven speed in run, otherwise a ramp down to standstill
    always_ff @(posedge hclk) begin
        if (servo_power_on && brake_release_out && !stopping) begin
            speed_rpm <= set_rpm;
        end else begin
            speed_rpm <= speed_rpm > step ? speed_rpm - step : 16'h0;
        end
    end
endmodule
`default_nettype wire

// File: test/tb.sv
// Purpose: self-checking bench for the stop and brake sequencer
// Assumes: UNIT_CYC of 4, so one delay unit is 4 clocks
// Notes:   standstill stop, selection sweep, supply loss, regen trip
`timescale 1ns/1ps
`default_nettype none
module tb;
    import ssb_pkg::*;
    logic hclk = 1'h0, hresetn = 1'h0, hsel = 1'h0, hwrite = 1'h0, run_cmd = 1'h0;
    logic protect_trip = 1'h0, main_supply_ok = 1'h1, hreadyout, hresp, servo_power_on;
    logic cmd_dyn_brake, cmd_free_run, cmd_estop, cmd_servo_free, brake_release_out;
    logic dev_counter_clear, regen_enable, regen_alarm, undervoltage_alarm, supply_shutoff;
    logic irq, stopping;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic [7:0] haddr = 8'h0;
    logic [6:0] regen_rate_pct = 7'h0;
    logic [15:0] speed_rpm, set_rpm = 16'h0;
    logic [31:0] hwdata = 32'h0, hrdata, rd;
    int miscompares = 0, total_checks = 0, n;
    wire hready = hreadyout; // the one slave drives bus ready
    assign stopping = cmd_dyn_brake | cmd_free_run | cmd_estop;
    ssb_sequencer #(.UNIT_CYC(4)) i_dut (.*);
    ssb_motor_model i_motor (.*);
    initial forever #4 hclk = ~hclk;
    ////////////////////////////////////////////////////////////////////////
    // one single word transfer; read data lands in rd
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge hclk);
        {hsel, haddr, htrans, hwrite} <= {1'h1, a, 2'h2, w};
        do @(posedge hclk); while (hreadyout !== 1'h1);
        {htrans, hwdata} <= {2'h0, d};
        do @(posedge hclk); while (hreadyout !== 1'h1);
        rd = hrdata;
    endtask
    task automatic ck(input logic [31:0] g, input logic [31:0] e);
        total_checks++;
        if (g !== e) begin
            miscompares++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
        end
    endtask
    // run command on, then let the drive settle in run
    task automatic spin(input logic [15:0] r);
        {set_rpm, run_cmd} <= {r, 1'h1};
        for (n = 0; n < 50 && servo_power_on !== 1'h1; n++) @(posedge hclk);
        repeat (4) @(posedge hclk);
    endtask
    task automatic tally_and_finish;
        $display("comparisons %0d miscompares %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (3) @(posedge hclk);
        hresetn <= 1'h1;
        bus(1'h0, ADDR_BRAKE, 32'h0);
        ck(rd, 32'h0032000a);
        bus(1'h0, 8'h18, 32'h0);
        ck(rd, 32'h0);
        // standstill: brake drops first, power ten units later
        spin(16'h0);
        run_cmd <= 1'h0;
        for (n = 0; n < 50 && brake_release_out === 1'h1; n++) @(negedge hclk);
        ck(servo_power_on, 1);
        for (n = 0; n < 99 && servo_power_on === 1'h1; n++) @(negedge hclk);
        ck(n >= 38 && n <= 42, 1);
        for (int s = 0; s < 10; s++) begin
            bus(1'h1, ADDR_CTRL, 32'h400 | (s << 4));
            spin(16'hc8);
            run_cmd <= 1'h0;
            for (n = 0; n < 50 && stopping !== 1'h1; n++) @(negedge hclk);
            ck({cmd_estop, cmd_free_run, cmd_dyn_brake}, s > 7 ? 4 : s % 2 ? 2 : 1);
            ck(dev_counter_clear, s < 4 || s > 7);
            for (n = 0; n < 300 && brake_release_out === 1'h1; n++) @(negedge hclk);
            ck(speed_rpm >= 14 && speed_rpm <= 30, 1);
            repeat (40) @(negedge hclk);
            ck(cmd_servo_free, s inside {2, 3, 6, 7, 9});
        end
        // supply lost in run: hold time, free-run stop, counter kept
        bus(1'h1, ADDR_CTRL, 32'h305);
        bus(1'h1, ADDR_IRQ_MASK, 32'h1);
        spin(16'h64);
        main_supply_ok <= 1'h0;
        for (n = 0; n < 400 && supply_shutoff !== 1'h1; n++) @(negedge hclk);
        ck(n >= 140 && n <= 146, 1);
        repeat (3) @(negedge hclk);
        ck(irq, 1);
        ck(cmd_free_run, 1);
        repeat (80) @(negedge hclk);
        ck({cmd_dyn_brake, dev_counter_clear, undervoltage_alarm}, 3'h4);
        bus(1'h1, ADDR_IRQ_STAT, 32'h1);
        @(negedge hclk);
        ck(irq, 0);
        // supply back is a power cycle; run is still held on
        @(posedge hclk);
        main_supply_ok <= 1'h0 + 1'h1;
        spin(16'h64);
        regen_rate_pct <= 7'h1;
        repeat (20) @(negedge hclk);
        ck(regen_alarm, 0);
        @(posedge hclk);
        regen_rate_pct <= 7'h2;
        for (n = 0; n < 50 && regen_alarm !== 1'h1; n++) @(negedge hclk);
        repeat (3) @(negedge hclk);
        ck({regen_alarm, cmd_free_run}, 2'h3);
        repeat (80) @(negedge hclk);
        ck(cmd_servo_free, 1);
        tally_and_finish;
    end
    initial begin
        repeat (20000) @(posedge hclk);
        miscompares++;
        tally_and_finish;
    end
endmodule
bind ssb_sequencer ssb_chk i_chk (.*);
`default_nettype wire
